/* hw/vmeic_levels.sv */
// Purpose: Per-level pending bits and per-line sent bits
// Assumes: Levels 7..4 route to request lines 3..0
// Notes: Set always wins over a same-cycle clear
`timescale 1ns/1ns
module vmeic_levels (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Level and line signals
   vmeic_lvl_if.trk lv
);
   logic [6:0] pend_r;
   logic [6:0] pend_nxt;
   logic [3:0] sent_r;
   logic [3:0] sent_nxt;
   logic [3:0] issue_r;
   logic [3:0] issue_nxt;

   // ----------------------------------------------------------------
   // Pending bits, one per level
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < vmeic_pkg::NLVL; gi++) begin : g_lvl
         // Clear source depends on interrupter release type
         always_comb begin
            pend_nxt[gi] = lv.irq[gi] |
               (pend_r[gi] & ~(lv.roak[gi] ? lv.ack[gi] : lv.sw_clr[gi]));
         end
      end
      // ----------------------------------------------------------------
      // Sent bits, one per request line
      // ----------------------------------------------------------------
      for (gi = 0; gi < vmeic_pkg::NLINE; gi++) begin : g_line
         // Each forwarded level owns exactly one line
         always_comb begin
            issue_nxt[gi] = lv.mask[gi + vmeic_pkg::FWD_BASE] &
               pend_r[gi + vmeic_pkg::FWD_BASE] & ~sent_r[gi];
            sent_nxt[gi] = issue_nxt[gi] | (sent_r[gi] & ~lv.ident[gi]);
         end
      end
   endgenerate

   // Registers only
   always_ff @(posedge clk) begin
      if (srst) begin
         pend_r <= 7'h00;
         sent_r <= 4'h0;
         issue_r <= 4'h0;
      end else begin
         pend_r <= pend_nxt;
         sent_r <= sent_nxt;
         issue_r <= issue_nxt;
      end
   end

   assign lv.pend = pend_r;
   assign lv.sent = sent_r;
   assign lv.issue = issue_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_pend_set: assert property (lv.irq[6] |=> pend_r[6])
      else $error("pending bit not set by asserted level");
   a_roak_clear: assert property (pend_r[6] && !lv.irq[6]
      && lv.roak[6] && lv.ack[6] |=> !pend_r[6])
      else $error("release-on-acknowledge pending did not clear");
   a_issue_sent: assert property ($rose(sent_r[0]) |-> issue_r[0])
      else $error("sent bit rose without an issue");
   a_issue_pulse: assert property (issue_r[3] |=> !issue_r[3])
      else $error("issue lasted more than one cycle");
   a_mask_block: assert property (!lv.mask[6] |=> !issue_r[3])
      else $error("masked level was forwarded");
   a_sent_hold: assert property (sent_r[2] && !lv.ident[2]
      |=> sent_r[2])
      else $error("sent bit dropped without identify");
   c_issue: cover property (issue_r[3] ##[1:20] lv.ident[3]);
   c_rora: cover property (pend_r[0] && !lv.roak[0] && lv.sw_clr[0]);
endmodule : vmeic_levels

/* hw/vmeic_lvl_if.sv */
// Purpose: Carries level and request-line signals between top and tracker
// Assumes: Bit i of level vectors is request level i+1
// Notes: None
`timescale 1ns/1ns
interface vmeic_lvl_if;
   logic [6:0] irq;
   logic [6:0] ack;
   logic [6:0] roak;
   logic [6:0] sw_clr;
   logic [6:0] mask;
   logic [6:0] pend;
   logic [3:0] ident;
   logic [3:0] sent;
   logic [3:0] issue;
   modport trk (input irq, ack, roak, sw_clr, mask, ident,
      output pend, sent, issue);
   modport top (output irq, ack, roak, sw_clr, mask, ident,
      input pend, sent, issue);
endinterface : vmeic_lvl_if

/* hw/vmeic_pkg.sv */
// Purpose: Shared constants for the VMEbus interrupt configuration block
// Assumes: One system clock, synchronous active-high reset
// Notes: Error enables occupy bits 24 down to 20 of the register
package vmeic_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CFG_OFF = 8'h4c;
   localparam int MASK_HI = 31;
   localparam int MASK_LO = 25;
   localparam int EN_HI = 24; // Bus error enable
   localparam int EN_LO = 20; // Transaction timeout enable
   localparam logic [6:0] MASK_RST = 7'h00;
   localparam logic [4:0] EN_RST = 5'h00;
   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NLVL = 7;
   localparam int NLINE = 4;
   localparam int NERR = 5;
   localparam int FWD_BASE = 3; // Level index 3 is IRQ4
   // Error event positions, aligned with enable bits 20..24
   localparam int ERR_BTO = 0;
   localparam int ERR_ARB = 1;
   localparam int ERR_PAR = 2;
   localparam int ERR_BSR = 3;
   localparam int ERR_BERR = 4;
endpackage : vmeic_pkg

/* hw/vmeic_top.sv */
// Purpose: Interrupt configuration register, level mask and error enables
// Assumes: Node-space base decode is done upstream; offset on REG_ADDR
// Notes: Bits 19..0 of the register read as zero
//
// Function
// - Levels seven to four forward, each to exactly one request line.
// - Mask bits 31..28 enable IRQ7 to IRQ4 forwarding; bits 27..25 are stored only; reset to zero.
// - Changing one level's mask leaves other pending levels undisturbed.
// - Bit 24 enables bus error interrupts; resets to zero.
// - Bit 23 enables swap RAM parity interrupts; resets to zero.
// - Bit 22 enables any of four bus parity faults as interrupt.
// - Bit 21 enables arbitration timeout interrupts; resets to zero.
// - Register answers at offset 0x4c within node space.
// - Pending per level; cleared by acknowledge or software by type.
// - Sent per line; set on issue, cleared by identify.
// - Bit 20 enables transaction timeout interrupts; resets to zero.
`timescale 1ns/1ns
module vmeic_top (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic SRST,
   // Register access
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   output logic REG_ACK,
   // VMEbus levels, bit i is level i+1
   input wire logic [6:0] IRQ_LEVEL,
   input wire logic [6:0] IRQ_ACK,
   input wire logic [6:0] IRQ_ROAK,
   input wire logic [6:0] PEND_CLR,
   output logic [6:0] IRQ_PEND,
   // System request lines
   input wire logic [3:0] LINE_IDENT,
   output logic [3:0] LINE_REQ,
   output logic [3:0] LINE_SENT,
   // Error events
   input wire logic BERR_SEEN,
   input wire logic SWAP_PAR_ERR,
   input wire logic VME_TX_PAR_ERR,
   input wire logic VME_RX_PAR_ERR,
   input wire logic INTERNAL_BUS_TX_PAR_ERR,
   input wire logic INTERNAL_BUS_RX_PAR_ERR,
   input wire logic ARB_TIMEOUT,
   input wire logic BUS_TIMEOUT,
   input wire logic [4:0] ERR_CLR,
   output logic [4:0] ERR_PEND,
   output logic ERR_INT
);
   logic [6:0] mask_r;
   logic [6:0] mask_nxt;
   logic [4:0] en_r;
   logic [4:0] en_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic ack_r;
   logic ack_nxt;
   logic [4:0] err_r;
   logic [4:0] err_nxt;
   logic [4:0] err_evt;
   logic hit;

   vmeic_lvl_if lv ();

   // ----------------------------------------------------------------
   // Register access
   // ----------------------------------------------------------------
   // Decode of the single configuration word
   assign hit = (REG_ADDR == vmeic_pkg::CFG_OFF);

   // Next register state; unmapped reads return zero
   always_comb begin
      mask_nxt = mask_r;
      en_nxt = en_r;
      rdata_nxt = rdata_r;
      ack_nxt = REG_WR | REG_RD;
      if (REG_WR && hit) begin
         mask_nxt = REG_WDATA[vmeic_pkg::MASK_HI:vmeic_pkg::MASK_LO];
         en_nxt = REG_WDATA[vmeic_pkg::EN_HI:vmeic_pkg::EN_LO];
      end
      if (REG_RD) begin
         rdata_nxt = hit ? {mask_r, en_r, 20'h00000} : 32'h00000000;
      end
   end

   // Reset leaves every level masked, software must open them
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         mask_r <= vmeic_pkg::MASK_RST;
         en_r <= vmeic_pkg::EN_RST;
         rdata_r <= 32'h00000000;
         ack_r <= 1'b0;
      end else begin
         mask_r <= mask_nxt;
         en_r <= en_nxt;
         rdata_r <= rdata_nxt;
         ack_r <= ack_nxt;
      end
   end

   assign REG_RDATA = rdata_r;
   assign REG_ACK = ack_r;

   // ----------------------------------------------------------------
   // Error interrupts
   // ----------------------------------------------------------------
   // Four parity sources share one enable
   always_comb begin
      err_evt = 5'h00;
      err_evt[vmeic_pkg::ERR_BTO] = BUS_TIMEOUT;
      err_evt[vmeic_pkg::ERR_ARB] = ARB_TIMEOUT;
      err_evt[vmeic_pkg::ERR_PAR] = VME_TX_PAR_ERR | VME_RX_PAR_ERR |
         INTERNAL_BUS_TX_PAR_ERR | INTERNAL_BUS_RX_PAR_ERR;
      err_evt[vmeic_pkg::ERR_BSR] = SWAP_PAR_ERR;
      err_evt[vmeic_pkg::ERR_BERR] = BERR_SEEN;
      // New event beats a same-cycle service clear
      err_nxt = (err_evt & en_r) | (err_r & ~ERR_CLR & en_r);
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         err_r <= 5'h00;
      end else begin
         err_r <= err_nxt;
      end
   end

   assign ERR_PEND = err_r;
   assign ERR_INT = |err_r;

   // ----------------------------------------------------------------
   // Level tracking
   // ----------------------------------------------------------------
   // Level inputs, clears, identify and the mask all feed tracking; status returns on plain ports
   assign lv.irq = IRQ_LEVEL;
   assign lv.ack = IRQ_ACK;
   assign lv.roak = IRQ_ROAK;
   assign lv.sw_clr = PEND_CLR;
   assign lv.mask = mask_r;
   assign lv.ident = LINE_IDENT;

   vmeic_levels u_levels (
      .clk(SYS_CLK),
      .srst(SRST),
      .lv(lv)
   );

   assign IRQ_PEND = lv.pend;
   assign LINE_SENT = lv.sent;
   assign LINE_REQ = lv.issue;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SRST);

   // Register bus; a hit write in between would change the readback
   a_cfg_write: assert property (REG_WR && hit ##1 !(REG_WR && hit)
      ##1 REG_RD && hit |=> REG_RDATA[31:25] == $past(REG_WDATA[31:25], 3))
      else $error("mask readback mismatch");
   a_cfg_reset: assert property ($past(SRST) |-> mask_r == 7'h00
      && en_r == 5'h00)
      else $error("register not cleared by reset");
   a_ack_time: assert property ((REG_RD || REG_WR) |=> REG_ACK)
      else $error("access not acknowledged next cycle");
   a_miss_zero: assert property (REG_RD && !hit
      |=> REG_RDATA == 32'h00000000)
      else $error("unmapped read not zero");
   a_rsvd_zero: assert property (REG_RD
      |=> REG_RDATA[19:0] == 20'h00000)
      else $error("unused register bits not zero");
   // Read data stands until the next read, so software may poll it
   a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
      else $error("read data changed without a read");

   // Error enables; a new event beats a clear, so no exception is needed
   a_err_gate: assert property (!en_r[4] && !en_nxt[4]
      |=> !ERR_PEND[4])
      else $error("disabled error raised interrupt");
   a_par_gate: assert property (!en_r[2] |=> !ERR_PEND[2])
      else $error("disabled parity error raised interrupt");
   a_berr_raise: assert property (BERR_SEEN && en_r[4]
      |=> ERR_INT)
      else $error("bus error did not interrupt");
   a_swap_raise: assert property (SWAP_PAR_ERR && en_r[3]
      |=> ERR_PEND[3])
      else $error("swap RAM parity error did not interrupt");
   a_par_raise: assert property (INTERNAL_BUS_RX_PAR_ERR && en_r[2]
      |=> ERR_PEND[2])
      else $error("parity error did not interrupt");
   a_arb_raise: assert property (ARB_TIMEOUT && en_r[1]
      |=> ERR_PEND[1])
      else $error("arbitration timeout did not interrupt");
   a_bto_raise: assert property (BUS_TIMEOUT && en_r[0]
      |=> ERR_PEND[0])
      else $error("transaction timeout did not interrupt");
   a_err_hold: assert property (ERR_PEND[1] && !ERR_CLR[1] && en_r[1]
      |=> ERR_PEND[1])
      else $error("error pending lost before service");

   // Levels seven to four are fixed to lines three to zero
   a_line_route: assert property (LINE_REQ[0]
      |-> $past(IRQ_PEND[3]) && $past(mask_r[3]))
      else $error("line request without its routed level");
   a_sent_rise: assert property (LINE_REQ[3] |-> LINE_SENT[3])
      else $error("sent bit not set with the request");
   // A mask write must leave an idle pending level alone
   a_pend_keep: assert property (!IRQ_LEVEL[3] && !PEND_CLR[3]
      && !(IRQ_ROAK[3] && IRQ_ACK[3]) |=> $stable(IRQ_PEND[3]))
      else $error("pending level disturbed");

   // Main scenarios
   c_write: cover property (REG_WR && hit && REG_WDATA[31:25] == 7'h78);
   c_err: cover property (ERR_INT ##[1:10] ERR_CLR != 5'h00);
   c_reissue: cover property (LINE_REQ[0] ##[2:300] LINE_REQ[0]);
endmodule : vmeic_top

/* tb/tb_vmeic_top.sv */
// Purpose: Self-checking bench for the interrupt configuration block
// Assumes: Bench inputs change on the falling edge of SYS_CLK; far-model outputs on the rising edge
// Notes: Random data from a bench LFSR with a fixed start
`timescale 1ns/1ns
module tb_vmeic_top;
   logic clk = 1'h0, srst = 1'h1, wr = 1'h0, rd = 1'h0, slow = 1'h0;
   logic [7:0] addr = 8'h00, ev = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, lf = 32'h00015848;
   logic [6:0] raise = 7'h00, roak = 7'h70, pclr = 7'h00;
   logic [6:0] irq, ack, pend;
   logic [3:0] ident, req, sent, seen = 4'h0;
   logic [4:0] eclr = 5'h00, epend, e;
   logic eint, rack;
   int miscompares = 0, checked = 0, cyc = 0;
   always #20 clk = ~clk;
   // Pulses are one cycle wide, so keep a sticky copy
   always @(posedge clk) seen <= seen | req;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         give_verdict();
      end
   end
   vmeic_top u_vmeic_top (.SYS_CLK(clk), .SRST(srst), .REG_WR(wr),
      .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_RDATA(rdata), .REG_ACK(rack), .IRQ_LEVEL(irq),
      .IRQ_ACK(ack), .IRQ_ROAK(roak), .PEND_CLR(pclr),
      .IRQ_PEND(pend), .LINE_IDENT(ident), .LINE_REQ(req),
      .LINE_SENT(sent), .BERR_SEEN(ev[0]), .SWAP_PAR_ERR(ev[1]),
      .VME_TX_PAR_ERR(ev[2]), .VME_RX_PAR_ERR(ev[3]),
      .INTERNAL_BUS_TX_PAR_ERR(ev[4]),
      .INTERNAL_BUS_RX_PAR_ERR(ev[5]),
      .ARB_TIMEOUT(ev[6]), .BUS_TIMEOUT(ev[7]), .ERR_CLR(eclr),
      .ERR_PEND(epend), .ERR_INT(eint));
   vmeic_far u_vmeic_far (.clk(clk), .srst(srst), .raise(raise),
      .slow(slow), .req(req), .irq(irq), .ack(ack), .ident(ident));
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nxt
   // Event k to its pending bit; four parity sources share one
   function automatic int eidx(input int k);
      return k == 0 ? 4 : k == 1 ? 3 : k < 6 ? 2 : k == 6 ? 1 : 0;
   endfunction : eidx
   task automatic chk(input logic [31:0] got, exp, input string m);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   // One register cycle; answer sampled while acknowledge is high
   task automatic acc(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(negedge clk);
      wr = w;
      rd = !w;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr = 1'h0;
      rd = 1'h0;
      chk(32'(rack), 32'h1, "ack");
   endtask : acc
   task automatic pulse_raise(input logic [6:0] v);
      @(negedge clk);
      raise = v;
      @(negedge clk);
      raise = 7'h00;
   endtask : pulse_raise
   task give_verdict();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (3) @(negedge clk);
      srst = 1'h0;
      acc(1'h0, 8'h4c, 32'h0);
      chk(rdata, 32'h0, "reset");
      // Masked level pends but is not forwarded
      pulse_raise(7'h40);
      repeat (4) @(negedge clk);
      chk(32'({pend, seen}), 32'h400, "masked");
      acc(1'h1, 8'h4c, {7'h78, 25'h0});
      for (int t = 0; t < 20 && sent[3] !== 1'h1; t++) @(negedge clk);
      // Sticky copy lags the pulse by a cycle, so add the live request
      chk(32'(seen | req), 32'h8, "level 7 line");
      for (int t = 0; t < 20 && sent[3] !== 1'h0; t++) @(negedge clk);
      chk(32'({pend, sent}), 32'h0, "identify");
      // Level 2 has no line; level 4 is software cleared
      slow = 1'h1;
      pulse_raise(7'h0a);
      for (int t = 0; t < 20 && sent[0] !== 1'h1; t++) @(negedge clk);
      // Line 3 stays in the sticky copy from the first transfer
      chk(32'(seen | req), 32'h9, "level 4 only");
      acc(1'h1, 8'h4c, {7'h38, 25'h0});
      chk(32'(pend), 32'h0a, "mask change");
      for (int t = 0; t < 20 && sent[0] !== 1'h0; t++) @(negedge clk);
      chk(32'(pend[3]), 32'h1, "sticky pend");
      pclr = 7'h08;
      @(negedge clk);
      pclr = 7'h00;
      @(negedge clk);
      chk(32'(pend[3]), 32'h0, "soft clear");
      // Random writes, ignored offset, unmapped read
      for (int i = 0; i < 4; i++) begin
         lf = nxt(lf);
         acc(1'h1, 8'h4c, lf);
         acc(1'h0, 8'h4c, 32'h0);
         chk(rdata, {lf[31:20], 20'h0}, "readback");
         acc(1'h1, 8'h48, ~lf);
         acc(1'h0, 8'h4c, 32'h0);
         chk(rdata, {lf[31:20], 20'h0}, "ignored write");
         acc(1'h0, 8'h50, 32'h0);
         chk(rdata, 32'h0, "unmapped");
      end
      // Each event with random enables, held then serviced
      for (int k = 0; k < 8; k++) begin
         lf = nxt(lf);
         acc(1'h1, 8'h4c, {7'h78, lf[4:0], 20'h0});
         ev[k] = 1'h1;
         @(negedge clk);
         ev = 8'h00;
         repeat (3) @(negedge clk);
         e = lf[eidx(k)] ? 5'h01 << eidx(k) : 5'h00;
         chk(32'(epend), 32'(e), "err pend");
         chk(32'(eint), 32'(|e), "err int");
         eclr = 5'h1f;
         @(negedge clk);
         eclr = 5'h00;
         @(negedge clk);
         chk(32'({eint, epend}), 32'h0, "err clear");
      end
      give_verdict();
   end
endmodule : tb_vmeic_top

/* tb/vmeic_far.sv */
// Purpose: Far-side model, interrupters and host
// Assumes: Host answers each line request after a delay
// Notes: Interrupter drops its level with the identify
`timescale 1ns/1ns
module vmeic_far (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Bench control
   input wire logic [6:0] raise,
   input wire logic slow,
   // Far-side signals
   input wire logic [3:0] req,
   output logic [6:0] irq = 7'h00,
   output logic [6:0] ack = 7'h00,
   output logic [3:0] ident = 4'h0
);
   logic [2:0] dly_r [4];
   // Slow mode leaves the line sent long enough to rewrite the mask
   always @(posedge clk) begin
      ident <= 4'h0;
      ack <= 7'h00;
      irq <= srst ? 7'h00 : (irq | raise);
      for (int j = 0; j < 4; j++) begin
         if (srst) dly_r[j] <= 3'h0;
         else if (req[j]) dly_r[j] <= slow ? 3'h6 : 3'h2;
         else if (dly_r[j] != 3'h0) dly_r[j] <= dly_r[j] - 3'h1;
         if (!srst && !req[j] && dly_r[j] == 3'h1) begin
            ident[j] <= 1'h1;
            ack[j+3] <= 1'h1;
            irq[j+3] <= 1'h0;
         end
      end
   end
endmodule : vmeic_far
